// [apf_aux_pin_ctrl.sv]
// Function selection for the aux multifunction pin and bus-pin general purpose I/O.
// Function
// - Code 0000 disables pin; 0001 reserved.
// - Code 0010 outputs jack detect, 1.75 ms.
// - 0011 general input; 0100 general output.
// - 0101-0111 mic data, both clock edges.
// - Code 1000 makes pin serial bit clock.
// - Code 1001 outputs headset OR button.
// - Code 1010 outputs OR of four interrupts.
// - Code 1011 outputs short-circuit OR AGC noise.
// - Codes 1100, 1101 output short-circuit only.
// - Code 1110 outputs AGC noise only.
// - Code 1111 outputs button press interrupt.
// - Bit D3 sets general output level.
// - Read-only D2 shows input pin level.
// - D1 zero: single 2 ms pulse.
// - D1 one: repeat until flags read.
// - SDA field: unused, input, output, reserved.
// - Bus pins only pull low, never drive.
// - D5 sets SDA output; D4 reads SDA.
// - SCL field at D3-D2, same encoding.
// - D1 sets SCL output; D0 reads SCL.
// - Bus pin controls only active in SPI.
`timescale 1ns/1ps
`default_nettype none

`include "apf_consts.svh"

module apf_aux_pin_ctrl
(
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire apf_pkg::apf_reg_req_t reg_req,
    output logic [7:0]                reg_rdata,
    input  wire apf_pkg::apf_irq_t    irq_evt,
    input  wire logic                 spi_select,
    input  wire logic                 bclk_out_en,
    input  wire logic                 bclk_out,
    output logic                      bclk_in,
    input  wire logic                 dmic_clk,
    output logic                      dmic_rise_data,
    output logic                      dmic_fall_data,
    output logic                      dmic_valid,
    input  wire logic                 aux_in,
    output apf_pkg::apf_pin_drv_t     aux_drv,
    input  wire logic                 sda_in,
    output apf_pkg::apf_pin_drv_t     sda_gpio_drv,
    output logic                      sda_gpio_active,
    input  wire logic                 scl_in,
    output apf_pkg::apf_pin_drv_t     scl_gpio_drv,
    output logic                      scl_gpio_active
);
    import apf_pkg::*;

    localparam logic [17:0] PULSE_LEN = 18'(`APF_PULSE_CYCLES);
    localparam logic [17:0] JACK_LEN  = 18'(`APF_JACK_PULSE_CYCLES);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] aux_ctrl_q;
    logic [7:0] aux_ctrl_d;
    logic [7:0] bus_gpio_q;
    logic [7:0] bus_gpio_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       aux_in_q;
    logic       sda_in_q;
    logic       scl_in_q;

    apf_func_t     func;
    apf_bus_mode_t sda_mode;
    apf_bus_mode_t scl_mode;
    logic          flags_read;

    assign func     = apf_func_t'(aux_ctrl_q[`APF_AUX_FUNC_HI:`APF_AUX_FUNC_LO]);
    assign sda_mode = apf_bus_mode_t'(bus_gpio_q[`APF_SDA_CTL_HI:`APF_SDA_CTL_LO]);
    assign scl_mode = apf_bus_mode_t'(bus_gpio_q[`APF_SCL_CTL_HI:`APF_SCL_CTL_LO]);
    // Reading the interrupt flags register acknowledges repeated pulses.
    assign flags_read = reg_req.rd && (reg_req.addr == `APF_IRQ_FLAGS_ADDR);

    always_comb
    begin
        aux_ctrl_d = aux_ctrl_q;
        bus_gpio_d = bus_gpio_q;
        rdata_d    = rdata_q;
        if (reg_req.wr && reg_req.addr == `APF_AUX_CTRL_ADDR)
        begin
            aux_ctrl_d = reg_req.wdata & 8'hfa;
        end
        if (reg_req.wr && reg_req.addr == `APF_BUS_GPIO_ADDR)
        begin
            bus_gpio_d = reg_req.wdata & 8'hee;
        end
        if (reg_req.rd)
        begin
            case (reg_req.addr)
                `APF_AUX_CTRL_ADDR:
                begin
                    rdata_d = aux_ctrl_q;
                    rdata_d[`APF_AUX_IN_BIT] = aux_in_q;
                end
                `APF_BUS_GPIO_ADDR:
                begin
                    rdata_d = bus_gpio_q;
                    rdata_d[`APF_SDA_IN_BIT] = sda_in_q;
                    rdata_d[`APF_SCL_IN_BIT] = scl_in_q;
                end
                default:
                begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            aux_ctrl_q <= `APF_AUX_CTRL_RESET;
            bus_gpio_q <= `APF_BUS_GPIO_RESET;
            rdata_q    <= 8'h00;
            aux_in_q   <= 1'b0;
            sda_in_q   <= 1'b0;
            scl_in_q   <= 1'b0;
        end
        else
        begin
            aux_ctrl_q <= aux_ctrl_d;
            bus_gpio_q <= bus_gpio_d;
            rdata_q    <= rdata_d;
            aux_in_q   <= aux_in;
            sda_in_q   <= sda_in;
            scl_in_q   <= scl_in;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // Interrupt selection and pulse shaping
    // ----------------------------------------
    logic irq_trig;
    logic irq_pulse;
    logic jack_pulse;

    always_comb
    begin
        case (func)
            APF_FN_HS_BTN: irq_trig = irq_evt.headset | irq_evt.button;
            APF_FN_ALL4:   irq_trig = |irq_evt;
            APF_FN_SC_AGC: irq_trig = irq_evt.short_ckt | irq_evt.agc_noise;
            APF_FN_SC0,
            APF_FN_SC1:    irq_trig = irq_evt.short_ckt;
            APF_FN_AGC:    irq_trig = irq_evt.agc_noise;
            APF_FN_BTN:    irq_trig = irq_evt.button;
            default:       irq_trig = 1'b0;
        endcase
    end

    apf_pulse_gen u_irq_pulse
    (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .trig        (irq_trig),
        .repeat_mode (aux_ctrl_q[`APF_AUX_DUR_BIT]),
        .ack         (flags_read),
        .len         (PULSE_LEN),
        .pulse       (irq_pulse)
    );

    apf_pulse_gen u_jack_pulse
    (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .trig        (func == APF_FN_JACK && irq_evt.headset),
        .repeat_mode (1'b0),
        .ack         (1'b0),
        .len         (JACK_LEN),
        .pulse       (jack_pulse)
    );

    // ----------------------------------------
    // Microphone capture
    // ----------------------------------------
    logic dmic_en;

    assign dmic_en = (func == APF_FN_DMIC0) || (func == APF_FN_DMIC1) ||
                     (func == APF_FN_DMIC2);

    apf_dmic_capture u_dmic
    (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .enable     (dmic_en),
        .dmic_clk   (dmic_clk),
        .data_in    (aux_in),
        .rise_data  (dmic_rise_data),
        .fall_data  (dmic_fall_data),
        .data_valid (dmic_valid)
    );

    // ----------------------------------------
    // Aux pin driver
    // ----------------------------------------
    always_comb
    begin
        aux_drv.o    = 1'b0;
        aux_drv.oe_n = 1'b1;
        bclk_in      = 1'b0;
        case (func)
            APF_FN_OFF,
            APF_FN_RSVD,
            APF_FN_GPI,
            APF_FN_DMIC0,
            APF_FN_DMIC1,
            APF_FN_DMIC2:
            begin
                aux_drv.oe_n = 1'b1;
            end
            APF_FN_JACK:
            begin
                aux_drv.o    = jack_pulse;
                aux_drv.oe_n = 1'b0;
            end
            APF_FN_GPO:
            begin
                aux_drv.o    = aux_ctrl_q[`APF_AUX_OUT_BIT];
                aux_drv.oe_n = 1'b0;
            end
            APF_FN_BCLK:
            begin
                aux_drv.o    = bclk_out;
                aux_drv.oe_n = !bclk_out_en;
                bclk_in      = aux_in;
            end
            default:
            begin
                aux_drv.o    = irq_pulse;
                aux_drv.oe_n = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Bus pins as open-drain general purpose I/O
    // ----------------------------------------
    // Gated by SPI select
    assign sda_gpio_active = spi_select && (sda_mode == APF_BP_IN || sda_mode == APF_BP_OUT);
    assign scl_gpio_active = spi_select && (scl_mode == APF_BP_IN || scl_mode == APF_BP_OUT);

    // Pull low only in output mode
    assign sda_gpio_drv.o    = 1'b0;
    assign sda_gpio_drv.oe_n = !(spi_select && sda_mode == APF_BP_OUT &&
                                 !bus_gpio_q[`APF_SDA_OUT_BIT]);
    assign scl_gpio_drv.o    = 1'b0;
    assign scl_gpio_drv.oe_n = !(spi_select && scl_mode == APF_BP_OUT &&
                                 !bus_gpio_q[`APF_SCL_OUT_BIT]);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_gpo_level;
        @(posedge mclk) disable iff (!reset_n)
        (func == APF_FN_GPO) |-> (!aux_drv.oe_n && aux_drv.o == aux_ctrl_q[3]);
    endproperty
    a_gpo_level: assert property (p_gpo_level) else $error("aux output level wrong");

    property p_off_released;
        @(posedge mclk) disable iff (!reset_n)
        (func == APF_FN_OFF || func == APF_FN_GPI) |-> aux_drv.oe_n;
    endproperty
    a_off_released: assert property (p_off_released) else $error("aux driven when off");

    property p_no_sda_high;
        @(posedge mclk) disable iff (!reset_n)
        !sda_gpio_drv.oe_n |-> !sda_gpio_drv.o;
    endproperty
    a_no_sda_high: assert property (p_no_sda_high) else $error("SDA driven high");

    property p_spi_gate;
        @(posedge mclk) disable iff (!reset_n)
        !spi_select |-> (sda_gpio_drv.oe_n && scl_gpio_drv.oe_n);
    endproperty
    a_spi_gate: assert property (p_spi_gate) else $error("bus pin driven outside SPI");

    property p_in_readback;
        @(posedge mclk) disable iff (!reset_n)
        reg_req.rd && reg_req.addr == `APF_AUX_CTRL_ADDR |=> reg_rdata[2] == $past(aux_in, 2);
    endproperty
    a_in_readback: assert property (p_in_readback) else $error("aux input readback wrong");

    property p_rsvd_zero;
        @(posedge mclk) disable iff (!reset_n)
        aux_ctrl_q[0] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

    property p_single_pulse;
        @(posedge mclk) disable iff (!reset_n)
        (func == APF_FN_SC0 && !aux_ctrl_q[1] && irq_evt.short_ckt && !irq_pulse
         && !u_irq_pulse.busy_q) |=> irq_pulse [*8];
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("pulse not started");

    property p_scl_low;
        @(posedge mclk) disable iff (!reset_n)
        (spi_select && scl_mode == APF_BP_OUT && !bus_gpio_q[1]) |-> !scl_gpio_drv.oe_n;
    endproperty
    a_scl_low: assert property (p_scl_low) else $error("SCL not pulled low");

endmodule : apf_aux_pin_ctrl

`default_nettype wire

// [apf_consts.svh]
// Register offsets, field positions, reset values and timing counts for the aux pin block.
`ifndef APF_CONSTS_SVH
`define APF_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define APF_AUX_CTRL_ADDR     7'h63
`define APF_BUS_GPIO_ADDR     7'h64
`define APF_IRQ_FLAGS_ADDR    7'h60

// ----------------------------------------
// Field positions
// ----------------------------------------
`define APF_AUX_FUNC_HI       7
`define APF_AUX_FUNC_LO       4
`define APF_AUX_OUT_BIT       3
`define APF_AUX_IN_BIT        2
`define APF_AUX_DUR_BIT       1
`define APF_SDA_CTL_HI        7
`define APF_SDA_CTL_LO        6
`define APF_SDA_OUT_BIT       5
`define APF_SDA_IN_BIT        4
`define APF_SCL_CTL_HI        3
`define APF_SCL_CTL_LO        2
`define APF_SCL_OUT_BIT       1
`define APF_SCL_IN_BIT        0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define APF_AUX_CTRL_RESET    8'h00
`define APF_BUS_GPIO_RESET    8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define APF_CLK_PERIOD_NS     10
`define APF_PULSE_NS          2000000
`define APF_PULSE_CYCLES      (`APF_PULSE_NS / `APF_CLK_PERIOD_NS)
`define APF_JACK_PULSE_NS     1750000
`define APF_JACK_PULSE_CYCLES (`APF_JACK_PULSE_NS / `APF_CLK_PERIOD_NS)

`endif

// [apf_dmic_capture.sv]
// Digital microphone data capture on both edges of the microphone clock.
`timescale 1ns/1ps
`default_nettype none

module apf_dmic_capture
(
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic dmic_clk,
    input  wire logic data_in,
    output logic      rise_data,
    output logic      fall_data,
    output logic      data_valid
);
    import apf_pkg::*;

    logic clk_prev_q;
    logic clk_prev_d;
    logic rise_q;
    logic rise_d;
    logic fall_q;
    logic fall_d;
    logic vld_q;
    logic vld_d;

    always_comb
    begin
        clk_prev_d = dmic_clk;
        rise_d     = rise_q;
        fall_d     = fall_q;
        vld_d      = 1'b0;
        if (enable && dmic_clk && !clk_prev_q)
        begin
            rise_d = data_in;
        end
        if (enable && !dmic_clk && clk_prev_q)
        begin
            fall_d = data_in;
            vld_d  = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            clk_prev_q <= 1'b0;
            rise_q     <= 1'b0;
            fall_q     <= 1'b0;
            vld_q      <= 1'b0;
        end
        else
        begin
            clk_prev_q <= clk_prev_d;
            rise_q     <= rise_d;
            fall_q     <= fall_d;
            vld_q      <= vld_d;
        end
    end

    assign rise_data  = rise_q;
    assign fall_data  = fall_q;
    assign data_valid = vld_q;

endmodule : apf_dmic_capture

`default_nettype wire

// [apf_pin_model.sv]
// Pin surroundings: pull-ups on the bus pins and an outside driver on the aux pin.
`timescale 1ns/1ps
`default_nettype none

module apf_pin_model
(
    input  wire logic                  mclk,
    input  wire apf_pkg::apf_pin_drv_t aux_drv,
    input  wire apf_pkg::apf_pin_drv_t sda_drv,
    input  wire apf_pkg::apf_pin_drv_t scl_drv,
    input  wire logic                  ext_en,
    input  wire logic                  ext_val,
    input  wire logic                  sda_pull_low,
    input  wire logic                  scl_pull_low,
    output logic                       aux_in,
    output logic                       sda_in,
    output logic                       scl_in
);
    import apf_pkg::*;

    logic float_q = 1'b0;

    // The aux pin has no pull resistor, so a floating pin toggles rather than hold a stale level.
    always_ff @(posedge mclk)
        float_q <= ~float_q;

    always_comb
    begin
        if (!aux_drv.oe_n)
            aux_in = aux_drv.o;
        else if (ext_en)
            aux_in = ext_val;
        else
            aux_in = float_q;
    end

    assign sda_in = !((!sda_drv.oe_n && !sda_drv.o) || sda_pull_low);
    assign scl_in = !((!scl_drv.oe_n && !scl_drv.o) || scl_pull_low);
endmodule : apf_pin_model

`default_nettype wire

// [apf_pkg.sv]
// Types shared by the aux pin function block.
package apf_pkg;

    typedef enum logic [3:0] {
        APF_FN_OFF      = 4'b0000,
        APF_FN_RSVD     = 4'b0001,
        APF_FN_JACK     = 4'b0010,
        APF_FN_GPI      = 4'b0011,
        APF_FN_GPO      = 4'b0100,
        APF_FN_DMIC0    = 4'b0101,
        APF_FN_DMIC1    = 4'b0110,
        APF_FN_DMIC2    = 4'b0111,
        APF_FN_BCLK     = 4'b1000,
        APF_FN_HS_BTN   = 4'b1001,
        APF_FN_ALL4     = 4'b1010,
        APF_FN_SC_AGC   = 4'b1011,
        APF_FN_SC0      = 4'b1100,
        APF_FN_SC1      = 4'b1101,
        APF_FN_AGC      = 4'b1110,
        APF_FN_BTN      = 4'b1111
    } apf_func_t;

    typedef enum logic [1:0] {
        APF_BP_NONE = 2'b00,
        APF_BP_IN   = 2'b01,
        APF_BP_OUT  = 2'b10,
        APF_BP_RSVD = 2'b11
    } apf_bus_mode_t;

    // Interrupt sources arriving as one-cycle event pulses.
    typedef struct packed {
        logic headset;
        logic button;
        logic short_ckt;
        logic agc_noise;
    } apf_irq_t;

    // Register bus request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } apf_reg_req_t;

    // Open-drain or tristate pin: output, active-low enable.
    typedef struct packed {
        logic o;
        logic oe_n;
    } apf_pin_drv_t;

endpackage : apf_pkg

// [apf_pulse_gen.sv]
// Interrupt pulse shaper: single pulse or repeated pulses until acknowledged.
`timescale 1ns/1ps
`default_nettype none

`include "apf_consts.svh"

module apf_pulse_gen
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        trig,
    input  wire logic        repeat_mode,
    input  wire logic        ack,
    input  wire logic [17:0] len,
    output logic             pulse
);
    import apf_pkg::*;

    logic [17:0] cnt_q;
    logic [17:0] cnt_d;
    logic        busy_q;
    logic        busy_d;
    logic        pend_q;
    logic        pend_d;
    logic        hi_q;
    logic        hi_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        pend_d = pend_q;
        hi_d   = hi_q;
        // Pending stays armed in repeat mode; a new event wins over the ack.
        if (trig)
        begin
            pend_d = repeat_mode;
        end
        else if (ack || !repeat_mode)
        begin
            pend_d = 1'b0;
        end
        if (!busy_q)
        begin
            if (trig || pend_q)
            begin
                busy_d = 1'b1;
                hi_d   = 1'b1;
                cnt_d  = len - 18'h00001;
            end
        end
        else if (cnt_q != 18'h00000)
        begin
            cnt_d = cnt_q - 18'h00001;
        end
        else if (hi_q && pend_d)
        begin
            // Low gap between repeated pulses, one cycle longer than the pulse.
            hi_d  = 1'b0;
            cnt_d = len - 18'h00001;
        end
        else
        begin
            busy_d = 1'b0;
            hi_d   = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            cnt_q  <= 18'h00000;
            busy_q <= 1'b0;
            pend_q <= 1'b0;
            hi_q   <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            pend_q <= pend_d;
            hi_q   <= hi_d;
        end
    end

    assign pulse = hi_q;

endmodule : apf_pulse_gen

`default_nettype wire

// [aux_pin_function_control_tb_top.sv]
// Self-checking bench for the aux pin function block.
`timescale 1ns/1ps
`default_nettype none

module aux_pin_function_control_tb_top;
    import apf_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic         mclk    = 1'b0;
    logic         reset_n = 1'b0;
    apf_reg_req_t req     = '0;
    apf_irq_t     irq     = '0;
    logic         spi     = 1'b0;
    logic         bo_en   = 1'b0;
    logic         bo      = 1'b0;
    logic         dclk    = 1'b0;
    logic         ext_en  = 1'b0;
    logic         ext_v   = 1'b0;
    logic         sda_pd  = 1'b0;
    logic         scl_pd  = 1'b0;
    logic [7:0]   rdata;
    logic         bi, mr, mf, mv, aux_in, sda_in, scl_in, sda_act, scl_act;
    apf_pin_drv_t aux, sda, scl;
    int           err_total   = 0;
    int           check_count = 0;
    logic [31:0]  seed        = 32'h793f7ab7;
    logic [3:0]   codes [8]   = '{4'h2, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    logic [3:0]   srcs  [8]   = '{4'h8, 4'hc, 4'hf, 4'h3, 4'h2, 4'h2, 4'h1, 4'h4};

    apf_aux_pin_ctrl i_dut (.mclk(mclk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata),
        .irq_evt(irq), .spi_select(spi), .bclk_out_en(bo_en), .bclk_out(bo), .bclk_in(bi),
        .dmic_clk(dclk), .dmic_rise_data(mr), .dmic_fall_data(mf), .dmic_valid(mv),
        .aux_in(aux_in), .aux_drv(aux), .sda_in(sda_in), .sda_gpio_drv(sda),
        .sda_gpio_active(sda_act), .scl_in(scl_in), .scl_gpio_drv(scl),
        .scl_gpio_active(scl_act));

    apf_pin_model i_pins (.mclk(mclk), .aux_drv(aux), .sda_drv(sda), .scl_drv(scl),
        .ext_en(ext_en), .ext_val(ext_v), .sda_pull_low(sda_pd), .scl_pull_low(scl_pd),
        .aux_in(aux_in), .sda_in(sda_in), .scl_in(scl_in));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        cyc(1);
        req = '0;
        cyc(1);
    endtask : reg_wr

    task automatic reg_rd(input logic [6:0] a, output logic [7:0] d);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        cyc(1);
        req = '0;
        cyc(1);
        d = rdata;
    endtask : reg_rd

    task automatic reset_dut(input int n);
        reset_n = 1'b0;
        cyc(n);
        reset_n = 1'b1;
        cyc(1);
    endtask : reset_dut

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        #100us;
        err_total++;
        finish_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        logic [7:0] d, a63, a64;
        logic       q [$];
        cyc(1);
        reset_dut(5);
        reg_rd(7'h63, d);
        check(d & 8'hfb, 8'h00, "aux ctrl reset");
        reg_rd(7'h64, d);
        check(d & 8'hee, 8'h00, "bus gpio reset");
        check(8'(aux.oe_n), 8'h01, "aux released after reset");
        for (int i = 0; i < 8; i++)
        begin
            // Host keeps reserved bits and codes out
            a63 = 8'(rnd()) & 8'hfe;
            if (a63[7:4] == 4'h1)
                a63[7:4] = 4'h0;
            a64 = 8'(rnd());
            if (a64[7:6] == 2'b11)
                a64[7:6] = 2'b10;
            if (a64[3:2] == 2'b11)
                a64[3:2] = 2'b01;
            spi = a64[0];
            reg_wr(7'h63, a63);
            reg_wr(7'h64, a64);
            reg_wr(7'h65, 8'hff);
            reg_rd(7'h63, d);
            check(d & 8'hfb, a63 & 8'hfb, "aux ctrl readback");
            reg_rd(7'h64, d);
            check(d & 8'hee, a64 & 8'hee, "bus gpio readback");
            reg_rd(7'h65, d);
            check(d, 8'h00, "unmapped read");
        end
        $display("test registers done");
        for (int v = 0; v < 2; v++)
        begin
            ext_en = 1'b0;
            reg_wr(7'h63, {4'b0100, v[0], 3'b000});
            check(8'(aux.oe_n), 8'h00, "gpo enable");
            check(8'(aux.o), 8'(v[0]), "gpo level");
            d = 8'(rnd());
            ext_en = 1'b1;
            ext_v = d[0];
            reg_wr(7'h63, {4'b0011, v[0], 3'b000});
            cyc(2);
            reg_rd(7'h63, d);
            check(8'(d[2]), 8'(ext_v), "gpi level");
            check(8'(aux.oe_n), 8'h01, "gpi released");
            check(8'(bi), 8'h00, "bclk idle");
            reg_wr(7'h63, 8'h80);
            ext_v = v[0];
            cyc(1);
            check(8'(bi), 8'(v[0]), "bclk input");
            ext_en = 1'b0;
            bo_en = 1'b1;
            bo = !v[0];
            cyc(1);
            check(8'({aux.oe_n, aux.o}), 8'(!v[0]), "bclk output");
            bo_en = 1'b0;
            // The reserved code stays unwritten; a set output bit must not leak out.
            reg_wr(7'h63, {4'b0000, v[0], 3'b000});
            check(8'(aux.oe_n), 8'h01, "disabled pin released");
        end
        $display("test aux modes done");
        for (int v = 0; v < 2; v++)
        begin
            spi = 1'b1;
            reg_wr(7'h64, {2'b10, v[0], 1'b0, 2'b10, ~v[0], 1'b0});
            check(8'(sda.oe_n), 8'(v[0]), "sda output");
            check(8'(scl.oe_n), 8'(!v[0]), "scl output");
            check(8'({sda.o, scl.o, sda_act, scl_act}), 8'h03, "open drain");
            sda_pd = v[0];
            scl_pd = ~v[0];
            reg_wr(7'h64, 8'h44);
            cyc(2);
            reg_rd(7'h64, d);
            check(d & 8'h11, {3'b000, ~v[0], 3'b000, v[0]}, "bus pin input");
            check(8'({sda.oe_n, scl.oe_n}), 8'h03, "bus input released");
            spi = 1'b0;
            reg_wr(7'h64, 8'h88);
            check(8'({sda_act, scl_act, sda.oe_n, scl.oe_n}), 8'h03, "spi off");
            spi = 1'b1;
            reg_wr(7'h64, 8'h00);
            check(8'({sda_act, scl_act}), 8'h00, "not gpio");
            sda_pd = 1'b0;
            scl_pd = 1'b0;
        end
        $display("test bus pins done");
        for (int c = 0; c < 8; c++)
            for (int s = 0; s < 4; s++)
            begin
                reset_dut(2);
                reg_wr(7'h63, {codes[c], 4'h0});
                check(8'({aux.oe_n, aux.o}), 8'h00, "irq idle");
                irq = apf_irq_t'(4'h8 >> s);
                cyc(1);
                irq = '0;
                cyc(1);
                check(8'(aux.o), 8'(srcs[c][3 - s]), "irq start");
                cyc(6);
                check(8'(aux.o), 8'(srcs[c][3 - s]), "irq hold");
            end
        reset_dut(2);
        reg_wr(7'h63, 8'hc2);
        irq = '{headset: 1'b0, button: 1'b0, short_ckt: 1'b1, agc_noise: 1'b0};
        cyc(1);
        irq = '0;
        cyc(1);
        check(8'(aux.o), 8'h01, "repeat pulse");
        reg_rd(7'h60, d);
        check(8'(aux.o), 8'h01, "ack finishes period");
        $display("test interrupts done");
        reset_dut(2);
        ext_en = 1'b1;
        for (int c = 5; c < 8; c++)
        begin
            reg_wr(7'h63, {c[3:0], 4'h0});
            check(8'(aux.oe_n), 8'h01, "mic input");
            for (int k = 0; k < 4; k++)
            begin
                d = 8'(rnd());
                q.push_back(d[0]);
                q.push_back(d[1]);
                ext_v = d[0];
                cyc(4);
                dclk = 1'b1;
                cyc(4);
                ext_v = d[1];
                cyc(4);
                dclk = 1'b0;
                for (int n = 0; n < 8 && mv !== 1'b1; n++)
                    cyc(1);
                check(8'(mv), 8'h01, "mic valid");
                check(8'(mr), 8'(q.pop_front()), "mic rise data");
                check(8'(mf), 8'(q.pop_front()), "mic fall data");
                cyc(2);
            end
        end
        $display("test mic done");
        finish_test();
    end
endmodule : aux_pin_function_control_tb_top

`default_nettype wire
